// [core/dmc_pkg.sv]
package dmc_pkg;

  // Serial control word layout.
  localparam int          WORD_BITS    = 16;
  localparam int          IDX_HI       = 14;
  localparam int          IDX_LO       = 8;
  localparam int          DATA_HI      = 7;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  WORD_CNT     = 5'h10;

  // Register indices.
  localparam logic [6:0]  IDX_LEFT_ATT = 7'h10;
  localparam logic [6:0]  IDX_RIGHT_ATT = 7'h11;
  localparam logic [6:0]  IDX_MUTE_OVR = 7'h12;
  localparam logic [6:0]  IDX_DAC_DEEMPHASIS_PIN = 7'h13;
  localparam logic [6:0]  IDX_FORMAT   = 7'h14;
  localparam logic [6:0]  IDX_ZERO     = 7'h16;

  // Field positions.
  localparam int          BIT_SOFT_RESET_REQUEST     = 7;
  localparam int          BIT_OVER     = 6;
  localparam int          BIT_MUTE_R   = 1;
  localparam int          BIT_MUTE_L   = 0;
  localparam int          DMF_HI       = 6;
  localparam int          DMF_LO       = 5;
  localparam int          BIT_DEEMPH   = 4;
  localparam int          BIT_DAC_R    = 1;
  localparam int          BIT_DAC_L    = 0;
  localparam int          BIT_FLT      = 5;
  localparam int          FMT_HI       = 2;
  localparam int          BIT_COMMON_ZERO_FLAG_SELECT     = 2;
  localparam int          BIT_ZERO_FLAG_INVERT     = 1;
  localparam int          BIT_OUTPUT_PHASE_INVERT     = 0;

  // Values after reset.
  localparam logic [7:0]  ATT_RESET    = 8'hff;
  localparam logic [1:0]  PAIR_RESET   = 2'h0;
  localparam logic        BIT_RESET    = 1'h0;
  localparam logic [1:0]  DMF_RESET    = 2'h0;
  localparam logic [2:0]  FMT_RESET    = 3'h5;
  localparam logic [5:0]  PIN_RESET    = 6'h01;

  // Format codes and the zero flag select used by the strapped variant.
  localparam logic [2:0]  FMT_CODE_I2S = 3'h4;
  localparam logic [2:0]  FMT_CODE_RJ16 = 3'h0;
  localparam logic        HW_COMMON_ZERO_FLAG_SELECT      = 1'h1;

  // Attenuator ramp.
  localparam logic [7:0]  ATT_MUTE     = 8'h80;
  localparam logic [2:0]  RAMP_LAST    = 3'h7;

  // Pin vector positions.
  localparam int          PIN_LATCH    = 0;
  localparam int          PIN_FMT      = 1;
  localparam int          PIN_DEEMPHASIS_PIN     = 2;
  localparam int          PIN_MUTE     = 3;
  localparam int          PIN_HW       = 4;
  localparam int          PIN_LR       = 5;

endpackage : dmc_pkg

// [core/dmc_mode_ctrl_port.sv]
// Behaviour
// - Format pin picks I2S or 16-bit right-justified.
// - De-emphasis pin high enables 44.1 kHz de-emphasis.
// - Mute pin high applies soft mute.
// - Strapped variant always uses 64x oversampling.
// - Control port independent of audio clocks.
// - Three lines: data, bit clock, latch.
// - One 16-bit word per write, MSB first.
// - Bits 14:8 are the register index.
// - Bits 7:0 are the register data.
// - Latch rising edge commits the word.
// - Indices 10h-14h and 16h are decoded.
// - 10h/11h hold attenuation, default none.
// - 12h: reset, oversample, mutes, zero defaults.
// - 13h: de-emphasis rate, enable, DAC disables.
// - 14h: roll-off bit 5, format 2:0.
// - 16h bit 2 common zero flag.
// - 16h bits 1:0 flag and phase invert.
// - Codes up to 128 mean infinite attenuation.
// - Soft mute ramps one step per eight samples.
// - Soft reset restores all defaults.
`timescale 1ns/10ps
`default_nettype none

module dmc_mode_ctrl_port
  import dmc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ctrl_bit_clock,
  input  wire logic       ctrl_latch,
  input  wire logic       ctrl_serial_data,
  input  wire logic       hw_control_mode,
  input  wire logic       format_select,
  input  wire logic       deemphasis_pin,
  input  wire logic       mute_pin,
  input  wire logic       lr_clock,
  output logic [7:0]      left_atten_out,
  output logic [7:0]      right_atten_out,
  output logic            oversample_select,
  output logic [1:0]      dac_disable,
  output logic            deemph_enable,
  output logic [1:0]      deemph_rate_select,
  output logic [2:0]      audio_format,
  output logic            rolloff_select,
  output logic            common_zero_flag_select,
  output logic            zero_flag_invert,
  output logic            output_phase_invert
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: shift register on the control bit clock.
  // Only two things live on the controller's clock: the word being shifted
  // in and a count of the bits seen. Nothing here is written from the core
  // side, so the crossing is one way. The core reads both only after it has
  // seen the latch high through its own synchroniser, by which time the
  // controller has stopped clocking and the values are frozen.

  logic [WORD_BITS-1:0]   shift_r;
  logic [CNT_W-1:0]       bit_cnt_r;

  // Shift the data line in MSB first while the latch is low. The bit clock
  // stands still outside frames, so reset has to act without it; the reset
  // only ever loads constants here.
  always_ff @(posedge ctrl_bit_clock or posedge rst) begin
    if (rst) begin
      shift_r <= '0;
    end else if (!ctrl_latch) begin
      shift_r <= {shift_r[WORD_BITS-2:0], ctrl_serial_data};
    end
  end

  // Free-running count of bits shifted; it wraps freely at 32 on purpose.
  // Free-running count of bits shifted; the core compares snapshots, so the
  // counter never needs clearing from the other domain.
  always_ff @(posedge ctrl_bit_clock or posedge rst) begin
    if (rst) begin
      bit_cnt_r <= '0;
    end else if (!ctrl_latch) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers in the core domain.
  // The latch, the straps and the word clock all arrive with no known phase
  // to the core clock. They share one vector so that every pin sees the same
  // lag; a strap change therefore reaches the outputs a few cycles late,
  // which is harmless for levels that are set once at power-up.

  logic [5:0]             pin_raw;
  logic [5:0]             pin_s1_r;
  logic [5:0]             pin_s2_r;
  logic [5:0]             pin_s3_r;
  logic [5:0]             pin_filt_r;
  logic [5:0]             pin_filt_nxt;
  logic [5:0]             pin_rise;

  assign pin_raw = {lr_clock, hw_control_mode, mute_pin, deemphasis_pin,
                    format_select, ctrl_latch};

  // Three flops per pin; the latch resets high so no false commit appears.
  // The word clock resets low, its idle level, so no false ramp tick either.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_r <= PIN_RESET;
      pin_s2_r <= PIN_RESET;
      pin_s3_r <= PIN_RESET;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // A level counts only once the second and third stages agree.
  // A glitch that reaches only one stage is ignored, which also keeps a slow
  // latch edge from committing the same word twice.
  assign pin_filt_nxt = (pin_s2_r & pin_s3_r) |
                        (pin_filt_r & (pin_s2_r | pin_s3_r));
  assign pin_rise     = pin_filt_nxt & ~pin_filt_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_filt_r <= PIN_RESET;
    end else begin
      pin_filt_r <= pin_filt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word commit.
  // A word is accepted only when exactly sixteen bit clock edges arrived in
  // the frame. The check works on the count difference modulo 32, so a frame
  // of 48 bits would also pass; a controller that keeps to the framing never
  // sends one, and the saving is a clear path back into the link domain.

  logic                   commit;
  logic [CNT_W-1:0]       cnt_prev_r;
  logic [CNT_W-1:0]       cnt_delta;
  logic                   word_ok;
  logic                   wr_en;
  logic [6:0]             wr_idx;
  logic [7:0]             wr_data;
  logic                   soft_reset_request_hit;
  logic                   clr;

  // The shift register and counter are read only at the filtered latch rise:
  // by then the latch has been high for several core cycles and no bit clock
  // may arrive, so the link-side words are stable when sampled.
  assign commit    = pin_rise[PIN_LATCH];
  assign cnt_delta = bit_cnt_r - cnt_prev_r;
  assign word_ok   = (cnt_delta == WORD_CNT);
  assign wr_en     = commit & word_ok;
  assign wr_idx    = shift_r[IDX_HI:IDX_LO];
  assign wr_data   = shift_r[DATA_HI:0];
  assign soft_reset_request_hit  = wr_en & (wr_idx == IDX_MUTE_OVR) & wr_data[BIT_SOFT_RESET_REQUEST];
  assign clr       = rst | soft_reset_request_hit;

  // Snapshot the bit count at each commit, good or bad, to frame the next.
  // Bad frames move the snapshot too, so one stray clock spoils one word only.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_prev_r <= '0;
    end else if (commit) begin
      cnt_prev_r <= bit_cnt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers. Each decodes its own index; any other index falls
  // through every branch and changes nothing.
  // Reserved bits are dropped on the way in, since nothing downstream uses
  // them and storing them would only add flops with no reader.

  logic [7:0]             left_atten_level_r;
  logic [7:0]             right_atten_level_r;
  logic [1:0]             soft_mute_enables_r;
  logic                   over_r;
  logic [1:0]             dac_dis_r;
  logic                   deemph_enable_r;
  logic [1:0]             deemph_rate_r;
  logic                   rolloff_r;
  logic [2:0]             fmt_r;
  logic                   common_zero_flag_select_r;
  logic                   zero_flag_invert_r;
  logic                   output_phase_invert_r;

  // Left attenuation level; the stored code is a target, the ramp below
  // decides how fast the output gets there.
  always_ff @(posedge core_clk) begin
    if (clr) begin
      left_atten_level_r <= ATT_RESET;
    end else if (wr_en && wr_idx == IDX_LEFT_ATT) begin
      left_atten_level_r <= wr_data;
    end
  end

  // Right attenuation level, decoded on its own index.
  always_ff @(posedge core_clk) begin
    if (clr) begin
      right_atten_level_r <= ATT_RESET;
    end else if (wr_en && wr_idx == IDX_RIGHT_ATT) begin
      right_atten_level_r <= wr_data;
    end
  end

  // Mute and oversampling; the soft-reset bit is not stored, it acts at once
  // and so reads back as its default.
  always_ff @(posedge core_clk) begin
    if (clr) begin
      soft_mute_enables_r <= PAIR_RESET;
      over_r              <= BIT_RESET;
    end else if (wr_en && wr_idx == IDX_MUTE_OVR) begin
      soft_mute_enables_r <= {wr_data[BIT_MUTE_R], wr_data[BIT_MUTE_L]};
      over_r              <= wr_data[BIT_OVER];
    end
  end

  // DAC disables and de-emphasis; the reserved rate code is stored as written.
  always_ff @(posedge core_clk) begin
    if (clr) begin
      dac_dis_r       <= PAIR_RESET;
      deemph_enable_r <= BIT_RESET;
      deemph_rate_r   <= DMF_RESET;
    end else if (wr_en && wr_idx == IDX_DAC_DEEMPHASIS_PIN) begin
      dac_dis_r       <= {wr_data[BIT_DAC_R], wr_data[BIT_DAC_L]};
      deemph_enable_r <= wr_data[BIT_DEEMPH];
      deemph_rate_r   <= wr_data[DMF_HI:DMF_LO];
    end
  end

  // Data format and filter roll-off.
  // Unused format codes are kept as written; the audio side decides on them.
  always_ff @(posedge core_clk) begin
    if (clr) begin
      rolloff_r <= BIT_RESET;
      fmt_r     <= FMT_RESET;
    end else if (wr_en && wr_idx == IDX_FORMAT) begin
      rolloff_r <= wr_data[BIT_FLT];
      fmt_r     <= wr_data[FMT_HI:0];
    end
  end

  // Zero flag and output phase controls.
  // Only the selects live here; the flag detection itself sits elsewhere.
  always_ff @(posedge core_clk) begin
    if (clr) begin
      common_zero_flag_select_r <= BIT_RESET;
      zero_flag_invert_r <= BIT_RESET;
      output_phase_invert_r <= BIT_RESET;
    end else if (wr_en && wr_idx == IDX_ZERO) begin
      common_zero_flag_select_r <= wr_data[BIT_COMMON_ZERO_FLAG_SELECT];
      zero_flag_invert_r <= wr_data[BIT_ZERO_FLAG_INVERT];
      output_phase_invert_r <= wr_data[BIT_OUTPUT_PHASE_INVERT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective mode selection between strapped pins and registers.
  // The registers keep taking writes while the strap is high; they simply
  // have no effect until the strap is released, and then their contents
  // apply at once, with no need to program them again.

  logic                   hw_mode;
  logic                   hw_mute;

  assign hw_mode = pin_filt_r[PIN_HW];
  assign hw_mute = pin_filt_r[PIN_MUTE];

  // Registered outputs; strapped values win while the strap is high.
  // Fields with no pin sit at their register defaults in the strapped
  // variant, except the zero flag, which is always common there.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      oversample_select       <= BIT_RESET;
      dac_disable             <= PAIR_RESET;
      deemph_enable           <= BIT_RESET;
      deemph_rate_select      <= DMF_RESET;
      audio_format            <= FMT_RESET;
      rolloff_select          <= BIT_RESET;
      common_zero_flag_select <= BIT_RESET;
      zero_flag_invert        <= BIT_RESET;
      output_phase_invert     <= BIT_RESET;
    end else if (hw_mode) begin
      oversample_select       <= BIT_RESET;
      dac_disable             <= PAIR_RESET;
      deemph_enable           <= pin_filt_r[PIN_DEEMPHASIS_PIN];
      deemph_rate_select      <= DMF_RESET;
      audio_format            <= pin_filt_r[PIN_FMT] ? FMT_CODE_RJ16
                                                     : FMT_CODE_I2S;
      rolloff_select          <= BIT_RESET;
      common_zero_flag_select <= HW_COMMON_ZERO_FLAG_SELECT;
      zero_flag_invert        <= BIT_RESET;
      output_phase_invert     <= BIT_RESET;
    end else begin
      oversample_select       <= over_r;
      dac_disable             <= dac_dis_r;
      deemph_enable           <= deemph_enable_r;
      deemph_rate_select      <= deemph_rate_r;
      audio_format            <= fmt_r;
      rolloff_select          <= rolloff_r;
      common_zero_flag_select <= common_zero_flag_select_r;
      zero_flag_invert        <= zero_flag_invert_r;
      output_phase_invert     <= output_phase_invert_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Attenuator ramp, paced by the synchronised word clock.
  // The ramp needs no relation between the word clock and the core clock
  // beyond the core being fast enough to see every word clock edge through
  // the synchroniser. A word clock faster than one edge per few core cycles
  // would lose steps, so the core clock must stay well above it.

  logic [2:0]             samp_cnt_r;
  logic                   ramp_step;

  // Count sample periods; a step is allowed once every eight of them.
  // Soft reset clears the count, so the first step after it is a full period.
  always_ff @(posedge core_clk) begin
    if (clr) begin
      samp_cnt_r <= '0;
    end else if (pin_rise[PIN_LR]) begin
      samp_cnt_r <= samp_cnt_r + 3'h1;
    end
  end

  assign ramp_step = pin_rise[PIN_LR] & (samp_cnt_r == RAMP_LAST);

  logic [7:0]             lvl_sel [2];
  logic [1:0]             mute_sel;
  logic [7:0]             ramp_tgt [2];
  logic [7:0]             ramp_cur_r [2];

  // In the strapped variant the level is fixed at none and one pin mutes
  // both channels; the ramp still runs so muting stays pop-free.
  assign lvl_sel[0]  = hw_mode ? ATT_RESET : left_atten_level_r;
  assign lvl_sel[1]  = hw_mode ? ATT_RESET : right_atten_level_r;
  assign mute_sel[0] = hw_mode ? hw_mute : soft_mute_enables_r[0];
  assign mute_sel[1] = hw_mode ? hw_mute : soft_mute_enables_r[1];

  for (genvar ch = 0; ch < 2; ch++) begin : g_ramp
    // Every code at or below the mute code ends at infinite attenuation.
    assign ramp_tgt[ch] = (mute_sel[ch] || lvl_sel[ch] <= ATT_MUTE) ?
                          ATT_MUTE : lvl_sel[ch];

    // Move one half-decibel step toward the target; large changes take
    // many steps, which is the price of a click-free output.
    always_ff @(posedge core_clk) begin
      if (clr) begin
        ramp_cur_r[ch] <= ATT_RESET;
      end else if (ramp_step && ramp_cur_r[ch] < ramp_tgt[ch]) begin
        ramp_cur_r[ch] <= ramp_cur_r[ch] + 8'h01;
      end else if (ramp_step && ramp_cur_r[ch] > ramp_tgt[ch]) begin
        ramp_cur_r[ch] <= ramp_cur_r[ch] - 8'h01;
      end
    end
  end

  // Current attenuator codes, taken straight from the ramp flops.
  // They are not retimed again: the ramp flops already run on the core clock
  // and change at most once every eight word clock periods.
  assign left_atten_out  = ramp_cur_r[0];
  assign right_atten_out = ramp_cur_r[1];

endmodule : dmc_mode_ctrl_port

`default_nettype wire

// [test/dmc_mode_ctrl_port_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module dmc_mode_ctrl_port_chk
  import dmc_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       ctrl_latch,
  input wire logic       hw_control_mode,
  input wire logic       format_select,
  input wire logic       deemphasis_pin,
  input wire logic       mute_pin,
  input wire logic [7:0] left_atten_out,
  input wire logic [7:0] right_atten_out,
  input wire logic       oversample_select,
  input wire logic       deemph_enable,
  input wire logic [2:0] audio_format
);
  // All checks live in the core domain and rest while reset is applied.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Pin checks wait eight cycles, which covers the synchroniser and filter lag.
  chk_reset_vals:
    assert property ($fell(rst) |-> left_atten_out == ATT_RESET && audio_format == FMT_RESET
      && !deemph_enable && !oversample_select) else $error("bad value after reset");
  chk_hw_format:
    assert property ((hw_control_mode && $stable(format_select))[*8] |->
      audio_format == (format_select ? FMT_CODE_RJ16 : FMT_CODE_I2S)) else $error("format pin");
  chk_hw_deemph:
    assert property ((hw_control_mode && $stable(deemphasis_pin))[*8] |->
      deemph_enable == deemphasis_pin) else $error("deemphasis pin");
  chk_hw_oversample:
    assert property (hw_control_mode[*8] |-> !oversample_select) else $error("oversampling");
  chk_hw_mute_hold:
    assert property ((hw_control_mode && mute_pin)[*8] |=>
      left_atten_out <= $past(left_atten_out)) else $error("mute pin");
  ////////////////////////////////////////////////////////////////////////////
  // The ramp moves one code at a time; a soft reset jump to full level is exempt.
  chk_atten_floor:
    assert property (left_atten_out >= ATT_MUTE && right_atten_out >= ATT_MUTE)
      else $error("attenuator below mute code");
  chk_ramp_unit:
    assert property ($changed(left_atten_out) && left_atten_out != ATT_RESET |->
      left_atten_out == $past(left_atten_out) + 8'h01 ||
      left_atten_out == $past(left_atten_out) - 8'h01) else $error("ramp step size");
  chk_ramp_spacing:
    assert property ($changed(right_atten_out) && right_atten_out != ATT_RESET |=>
      $stable(right_atten_out)[*8]) else $error("ramp steps too close");
  chk_latch_quiet:
    assert property ((!ctrl_latch && !hw_control_mode)[*8] |->
      $stable(audio_format) && $stable(deemph_enable)) else $error("update before latch");
  cover property (hw_control_mode && audio_format == FMT_CODE_RJ16);
  cover property (left_atten_out == ATT_MUTE);
  cover property (right_atten_out == ATT_MUTE && !hw_control_mode);
endmodule : dmc_mode_ctrl_port_chk
bind dmc_mode_ctrl_port dmc_mode_ctrl_port_chk u_dmc_mode_ctrl_port_chk (
  .core_clk(core_clk), .rst(rst), .ctrl_latch(ctrl_latch),
  .hw_control_mode(hw_control_mode), .format_select(format_select),
  .deemphasis_pin(deemphasis_pin), .mute_pin(mute_pin), .left_atten_out(left_atten_out),
  .right_atten_out(right_atten_out), .oversample_select(oversample_select),
  .deemph_enable(deemph_enable), .audio_format(audio_format));
`default_nettype wire

// [test/dmc_ctrl_host.sv]
`timescale 1ns/10ps
`default_nettype none
module dmc_ctrl_host (
  output var logic ctrl_latch,
  output var logic ctrl_bit_clock,
  output var logic ctrl_serial_data
);
  // Idle: latch high, bit clock parked low between frames.
  initial begin
    ctrl_latch       = 1'b1;
    ctrl_bit_clock   = 1'b0;
    ctrl_serial_data = 1'b0;
  end
  // Sends nb bits MSB first; the odd start offset keeps it unrelated to core_clk.
  task automatic send(input logic [23:0] w, input int nb);
    int i;
    #37;
    ctrl_latch = 1'b0;
    for (i = nb - 1; i >= 0; i--) begin
      ctrl_serial_data = w[i];
      #62.5 ctrl_bit_clock = 1'b1;
      #62.5 ctrl_bit_clock = 1'b0;
    end
    #62.5 ctrl_latch = 1'b1;
    // The data line is released; show the opposite level so stale bits never match.
    #62.5 ctrl_serial_data = ~ctrl_serial_data;
    #400;
  endtask : send
endmodule : dmc_ctrl_host
`default_nettype wire

// [test/test_dmc_mode_ctrl_port.sv]
`timescale 1ns/10ps
`default_nettype none
module test_dmc_mode_ctrl_port
  import dmc_pkg::*;
;
  localparam logic [15:0] DEF  = {3'h0, 1'b0, 2'h0, 1'b0, 2'h0, FMT_RESET, 1'b0, 3'h0};
  localparam logic [15:0] PROG = {3'h0, 1'b1, 2'h3, 1'b1, 2'h2, 3'h6, 1'b1, 3'h7};
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hw_control_mode = 1'b0;
  logic        format_select = 1'b0;
  logic        deemphasis_pin = 1'b0;
  logic        mute_pin = 1'b0;
  logic        lr_clock = 1'b0;
  logic [2:0]  lr_div = 3'h0;
  logic        ctrl_latch, ctrl_bit_clock, ctrl_serial_data;
  logic [7:0]  left_atten_out, right_atten_out;
  logic [1:0]  dac_disable, deemph_rate_select;
  logic [2:0]  audio_format;
  logic        oversample_select, deemph_enable, rolloff_select;
  logic        common_zero_flag_select, zero_flag_invert, output_phase_invert;
  logic [12:0] mode;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [6:0]  bad_idx [5] = '{7'h15, 7'h17, 7'h52, 7'h54, 7'h56};
  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs packed so one compare covers every field.
  assign mode = {oversample_select, dac_disable, deemph_enable, deemph_rate_select,
    audio_format, rolloff_select, common_zero_flag_select, zero_flag_invert,
    output_phase_invert};
  dmc_ctrl_host u_dmc_ctrl_host (.ctrl_latch(ctrl_latch), .ctrl_bit_clock(ctrl_bit_clock),
    .ctrl_serial_data(ctrl_serial_data));
  dmc_mode_ctrl_port u_dmc_mode_ctrl_port (.core_clk(core_clk), .rst(rst),
    .ctrl_bit_clock(ctrl_bit_clock), .ctrl_latch(ctrl_latch),
    .ctrl_serial_data(ctrl_serial_data), .hw_control_mode(hw_control_mode),
    .format_select(format_select), .deemphasis_pin(deemphasis_pin), .mute_pin(mute_pin),
    .lr_clock(lr_clock), .left_atten_out(left_atten_out), .right_atten_out(right_atten_out),
    .oversample_select(oversample_select), .dac_disable(dac_disable),
    .deemph_enable(deemph_enable), .deemph_rate_select(deemph_rate_select),
    .audio_format(audio_format), .rolloff_select(rolloff_select),
    .common_zero_flag_select(common_zero_flag_select), .zero_flag_invert(zero_flag_invert),
    .output_phase_invert(output_phase_invert));
  // Core clock; the word clock is slow so ramp steps are far apart.
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    lr_div   <= lr_div + 3'h1;
    lr_clock <= lr_div[2];
  end
  // A hang ends the run as a mismatch.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // Samples on the falling edge so outputs have settled.
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_cyc
  // Writes one control word and leaves room for the commit to reach the outputs.
  task automatic wr(input logic [6:0] idx, input logic [7:0] dat, input int nb = 16);
    u_dmc_ctrl_host.send({8'h00, 1'b0, idx, dat}, nb);
    wait_cyc(8);
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    wait_cyc(1);
    cmp({left_atten_out, right_atten_out}, {ATT_RESET, ATT_RESET});
    cmp({3'h0, mode}, DEF);
    wr(IDX_DAC_DEEMPHASIS_PIN, 8'h53);
    wr(IDX_FORMAT, 8'h26);
    wr(IDX_ZERO, 8'h07);
    wr(IDX_MUTE_OVR, 8'h40);
    cmp({3'h0, mode}, PROG);
    foreach (bad_idx[k]) wr(bad_idx[k], 8'h00);
    wr(IDX_FORMAT, 8'h00, 15);
    wr(IDX_FORMAT, 8'h00, 17);
    cmp({3'h0, mode}, PROG);
    wr(IDX_MUTE_OVR, 8'hc3);
    cmp({3'h0, mode}, DEF);
    wr(IDX_LEFT_ATT, 8'hfd);
    wr(IDX_RIGHT_ATT, 8'h10);
    wr(IDX_MUTE_OVR, 8'h01);
    wait_cyc(9000);
    cmp({left_atten_out, right_atten_out}, {ATT_MUTE, ATT_MUTE});
    wr(IDX_MUTE_OVR, 8'h02);
    wait_cyc(9000);
    cmp({left_atten_out, right_atten_out}, {8'hfd, ATT_MUTE});
    @(posedge core_clk);
    hw_control_mode <= 1'b1;
    deemphasis_pin  <= 1'b1;
    wait_cyc(10);
    wr(IDX_FORMAT, 8'h26);
    cmp({3'h0, mode}, {3'h0, 1'b0, 2'h0, 1'b1, 2'h0, FMT_CODE_I2S, 1'b0, 3'h4});
    @(posedge core_clk);
    format_select  <= 1'b1;
    deemphasis_pin <= 1'b0;
    mute_pin       <= 1'b1;
    wait_cyc(9000);
    cmp({3'h0, mode}, {3'h0, 1'b0, 2'h0, 1'b0, 2'h0, FMT_CODE_RJ16, 1'b0, 3'h4});
    cmp({left_atten_out, right_atten_out}, {ATT_MUTE, ATT_MUTE});
    tally_and_finish();
  end
endmodule : test_dmc_mode_ctrl_port
`default_nettype wire
